/* File: cser_defines.vh */
// constants for the clock event register block: offsets, field positions, reset values
// assumes inclusion by bare name from the design files of this folder
`ifndef CSER_DEFINES_VH
`define CSER_DEFINES_VH
`define CSER_EVENT_OFFSET 12'h008
`define CSER_EVENT_RESET 32'h0000_0000
`define CSER_FLAG_LSB 0
`define CSER_STUCK_FLAG_BIT 7
`define CSER_ENABLE_LSB 8
`define CSER_CLEAR_LSB 16
`define CSER_STUCK_CLEAR_BIT 23
`define CSER_NUM_SOURCES 7
`define CSER_RESP_OKAY 2'b00
`define CSER_RESP_SLVERR 2'b10
`endif

/* File: cser_flag_cell.v */
// one sticky event flag with gated set and write-one clear
// assumes set and clear are synchronous to clk
module cser_flag_cell (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire set_cond,
    input wire clear_req,
    output reg flag
);
    // set wins over a clear landing in the same cycle, so no event is lost
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (clk_en) begin
            if (set_cond) begin
                flag <= 1'b1;
            end else if (clear_req) begin
                flag <= 1'b0;
            end
        end
    end
endmodule // cser_flag_cell

/* File: cser_event_reg.v */
// clock event register: flags, enables and write-one clears behind an axi4-lite slave
// assumes status inputs synchronous to clk; bus single-beat, one write and one read at a time
// assumes clk_en stays high while a bus transfer is under way, since the readies do not look at it
// assumes a twelve-bit byte address; only the word at the event offset is mapped
`include "cser_defines.vh"
module cser_event_reg #(
    parameter ADDR_W = 12,
    parameter NSRC = `CSER_NUM_SOURCES
) (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [NSRC-1:0] source_stable,
    input wire fast_crystal_stuck,
    output wire clock_irq,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    reg aw_held;
    reg [ADDR_W-1:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [NSRC-1:0] stable_enable;
    wire [NSRC-1:0] stable_flag;
    wire stuck_crystal_flag;
    wire wr_fire;
    wire wr_hit;
    wire [NSRC-1:0] stable_clear;
    wire stuck_crystal_clear;
    wire [31:0] reg_view;
    wire rd_hit;
    wire enable_lane;
    wire clear_lane;
    wire [NSRC-1:0] stable_set;

    // word decode used by both read and write paths
    function hit;
        input [ADDR_W-1:0] a;
        begin
            hit = ({a[ADDR_W-1:2], 2'b00} == `CSER_EVENT_OFFSET);
        end
    endfunction

    // write address and data are each taken once and held until the response is raised; their readies stay low until it leaves
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_hit = wr_fire & hit(aw_addr);
    assign rd_hit = hit(s_axi_araddr);

    // write channel capture, either order
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response; unmapped word gets slverr and no effect
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSER_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= hit(aw_addr) ? `CSER_RESP_OKAY : `CSER_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte lane 1 carries the enables, byte lane 2 the write-one clears
    assign enable_lane = wr_hit & w_strb[1];
    assign clear_lane = wr_hit & w_strb[2];

    // enables are plain read-write in byte lane 1; bit 15 is not stored
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stable_enable <= {NSRC{1'b0}};
        end else if (clk_en) begin
            if (enable_lane) begin
                stable_enable <= w_data[`CSER_ENABLE_LSB +: NSRC];
            end
        end
    end

    // clear strobes are one-cycle pulses; a zero bit leaves its flag alone
    wire aux_pll_b_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 6];
    wire aux_pll_a_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 5];
    wire main_pll_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 4];
    wire fast_crystal_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 3];
    wire fast_rc_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 2];
    wire slow_crystal_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 1];
    wire slow_rc_stable_clear = clear_lane & w_data[`CSER_CLEAR_LSB + 0];
    assign stable_clear = {aux_pll_b_stable_clear, aux_pll_a_stable_clear, main_pll_stable_clear,
        fast_crystal_stable_clear, fast_rc_stable_clear, slow_crystal_stable_clear, slow_rc_stable_clear};
    assign stuck_crystal_clear = clear_lane & w_data[`CSER_STUCK_CLEAR_BIT];

    // a source can only raise its flag while its enable is one
    assign stable_set = source_stable & stable_enable;

    // stabilization flags gated by their enables
    genvar i;
    generate
        for (i = 0; i < NSRC; i = i + 1) begin : g_src
            cser_flag_cell u_flag (
                .clk(clk),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .set_cond(stable_set[i]),
                .clear_req(stable_clear[i]),
                .flag(stable_flag[i])
            );
        end
    endgenerate

    // stuck detection has no enable of its own
    cser_flag_cell u_stuck (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .set_cond(fast_crystal_stuck),
        .clear_req(stuck_crystal_clear),
        .flag(stuck_crystal_flag)
    );

    // named enable views; the read word layout is fixed at seven sources
    wire aux_pll_b_stable_enable = stable_enable[6];
    wire aux_pll_a_stable_enable = stable_enable[5];
    wire main_pll_stable_enable = stable_enable[4];
    wire fast_crystal_stable_enable = stable_enable[3];
    wire fast_rc_stable_enable = stable_enable[2];
    wire slow_crystal_stable_enable = stable_enable[1];
    wire slow_rc_stable_enable = stable_enable[0];

    // named flag views, same source order as the enables
    wire aux_pll_b_stable_flag = stable_flag[6];
    wire aux_pll_a_stable_flag = stable_flag[5];
    wire main_pll_stable_flag = stable_flag[4];
    wire fast_crystal_stable_flag = stable_flag[3];
    wire fast_rc_stable_flag = stable_flag[2];
    wire slow_crystal_stable_flag = stable_flag[1];
    wire slow_rc_stable_flag = stable_flag[0];

    // clear bits, bit 15 and 31:24 read zero; software must write zero there
    assign reg_view = {
        8'h00, // bits 31:24 have no function
        8'h00, // write-one clears always read back zero
        1'b0, // bit 15
        aux_pll_b_stable_enable,
        aux_pll_a_stable_enable,
        main_pll_stable_enable,
        fast_crystal_stable_enable,
        fast_rc_stable_enable,
        slow_crystal_stable_enable,
        slow_rc_stable_enable,
        stuck_crystal_flag,
        aux_pll_b_stable_flag,
        aux_pll_a_stable_flag,
        main_pll_stable_flag,
        fast_crystal_stable_flag,
        fast_rc_stable_flag,
        slow_crystal_stable_flag,
        slow_rc_stable_flag
    };

    // read path, one wait-free cycle after address acceptance
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `CSER_EVENT_RESET;
            s_axi_rresp <= `CSER_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? reg_view : 32'h0000_0000;
                s_axi_rresp <= rd_hit ? `CSER_RESP_OKAY : `CSER_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // combined request follows the eight flags directly
    assign clock_irq = stuck_crystal_flag | (|stable_flag);
endmodule // cser_event_reg

/* File: cser_event_reg_chk.sv */
// checker: bus timing and event flag properties of the event register
// assumes bind to the top module, clk_en high during bus traffic
module cser_event_reg_chk #(
    parameter NSRC = 7
) (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [NSRC-1:0] source_stable,
    input wire fast_crystal_stuck,
    input wire clock_irq,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
// both channels taken at one edge; the response register sets one edge later
wire wr_both_taken = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & clk_en;
AST_WR_RESP: assert property (wr_both_taken ##1 clk_en |=> s_axi_bvalid)
    else $error("write response missing");
AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read response missing");
AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
    else $error("write response repeated");
AST_RST_IRQ: assert property ($fell(sys_rst) |-> !clock_irq)
    else $error("irq high after reset");
AST_R_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0_0000)
    else $error("unused bits read nonzero");
AST_STUCK: assert property (fast_crystal_stuck && clk_en |=> clock_irq)
    else $error("stuck event lost");
AST_QUIET: assert property (!clock_irq && !fast_crystal_stuck && source_stable == 0 |=> !clock_irq)
    else $error("irq without cause");
// no write in flight means nothing may clear a flag
AST_STICKY: assert property (clock_irq && s_axi_awready && !s_axi_awvalid |=> clock_irq)
    else $error("flag dropped without clear");
cover property (s_axi_bvalid && s_axi_bready);
cover property (s_axi_rvalid && s_axi_rready);
cover property ($rose(clock_irq));
endmodule // cser_event_reg_chk
bind cser_event_reg cser_event_reg_chk #(.NSRC(NSRC)) u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .source_stable(source_stable),
    .fast_crystal_stuck(fast_crystal_stuck),
    .clock_irq(clock_irq),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

/* File: cser_event_reg_bench.sv */
// bench: axi4-lite tasks and event scenarios
// assumes design and checker compiled first
module cser_event_reg_bench;
timeunit 1ns;
timeprecision 1ns;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
logic clk = 0, sys_rst = 1, clk_en = 1, fast_crystal_stuck = 0, clock_irq;
logic [6:0] source_stable = 7'h00;
logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready, s_axi_bvalid, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 0;
logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
logic [3:0] s_axi_wstrb = 4'hf;
logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
int n_errors = 0, samples_checked = 0;
cser_event_reg u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .source_stable(source_stable),
    .fast_crystal_stuck(fast_crystal_stuck),
    .clock_irq(clock_irq),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
always #50 clk = ~clk;
task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task automatic guard(input int i);
    if (i >= 50) begin
        n_errors++;
        end_of_test;
    end
endtask
// ready sampled at the falling edge, valid released after the taking edge
task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
    int i;
    logic pa, pw, ta, tw, tb;
    logic [1:0] g;
    @(posedge clk);
    pa = 1; pw = 1; tb = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (i = 0; i < 50 && (pa || pw || !tb); i++) begin
        @(negedge clk);
        ta = s_axi_awready & pa; tw = s_axi_wready & pw; tb = s_axi_bvalid; g = s_axi_bresp;
        @(posedge clk);
        if (ta) begin pa = 0; s_axi_awvalid <= 0; end
        if (tw) begin pw = 0; s_axi_wvalid <= 0; end
    end
    s_axi_bready <= 0;
    guard(i);
    `CHK("bresp", r, g)
endtask
task automatic rc(input [11:0] a, input [31:0] e, input [1:0] r);
    int i;
    logic ta, tb;
    @(posedge clk);
    tb = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (i = 0; i < 50 && !tb; i++) begin
        @(negedge clk);
        ta = s_axi_arready; tb = s_axi_rvalid; rd_d = s_axi_rdata; rd_r = s_axi_rresp;
        @(posedge clk);
        if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    guard(i);
    `CHK("rdata", e, rd_d)
    `CHK("rresp", r, rd_r)
endtask
// main sequence: gating, sticky flags, partial clears, unmapped word, freeze, second reset
initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    rc(12'h008, 32'h0000_0000, 2'b00);
    source_stable <= 7'h2a;
    repeat (3) @(posedge clk);
    rc(12'h008, 32'h0000_0000, 2'b00);
    wr(12'h008, 32'h0000_7f00, 4'hf, 2'b00);
    rc(12'h008, 32'h0000_7f2a, 2'b00);
    source_stable <= 7'h00;
    wr(12'h008, 32'h0002_0000, 4'h4, 2'b00);
    rc(12'h008, 32'h0000_7f28, 2'b00);
    @(negedge clk);
    `CHK("irq", 1'b1, clock_irq)
    wr(12'h008, 32'h007f_0000, 4'hf, 2'b00);
    @(negedge clk);
    `CHK("irq", 1'b0, clock_irq)
    @(posedge clk);
    fast_crystal_stuck <= 1;
    @(posedge clk);
    fast_crystal_stuck <= 0;
    rc(12'h008, 32'h0000_0080, 2'b00);
    wr(12'h008, 32'h0000_0000, 4'hf, 2'b00);
    rc(12'h008, 32'h0000_0080, 2'b00);
    wr(12'h008, 32'h0080_0000, 4'hf, 2'b00);
    rc(12'h008, 32'h0000_0000, 2'b00);
    wr(12'h004, 32'h0000_7f00, 4'hf, 2'b10);
    rc(12'h004, 32'h0000_0000, 2'b10);
    rc(12'h008, 32'h0000_0000, 2'b00);
    // set beats a same-cycle clear; dropping the enable keeps a set flag
    source_stable <= 7'h01;
    wr(12'h008, 32'h0000_0100, 4'h2, 2'b00);
    wr(12'h008, 32'h0001_0000, 4'h4, 2'b00);
    rc(12'h008, 32'h0000_0101, 2'b00);
    source_stable <= 7'h00;
    wr(12'h008, 32'h0000_0000, 4'h2, 2'b00);
    rc(12'h008, 32'h0000_0001, 2'b00);
    wr(12'h008, 32'h0001_0000, 4'h4, 2'b00);
    rc(12'h008, 32'h0000_0000, 2'b00);
    // clk_en low: a stuck pulse must leave no trace
    @(posedge clk);
    clk_en <= 0;
    fast_crystal_stuck <= 1;
    repeat (3) @(posedge clk);
    fast_crystal_stuck <= 0;
    @(negedge clk);
    `CHK("irq", 1'b0, clock_irq)
    @(posedge clk);
    clk_en <= 1;
    rc(12'h008, 32'h0000_0000, 2'b00);
    // second reset with state set: everything reads zero again
    @(posedge clk);
    fast_crystal_stuck <= 1;
    @(posedge clk);
    fast_crystal_stuck <= 0;
    wr(12'h008, 32'h0000_7f00, 4'h2, 2'b00);
    rc(12'h008, 32'h0000_7f80, 2'b00);
    sys_rst <= 1;
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    @(negedge clk);
    `CHK("irq", 1'b0, clock_irq)
    rc(12'h008, 32'h0000_0000, 2'b00);
    end_of_test;
end
endmodule // cser_event_reg_bench
